// ==== tb/temp_sensor_value_config_regs_tb.sv ====
`default_nettype none
module temp_sensor_value_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, reset, reg_wr, reg_rd, conv_start, conv_done, busy;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [1:0] chan_enable, filter_on, conv_chan;
  logic [12:0] conv_raw;
  logic [25:0] raws;
  logic [4:0] delay;
  logic [12:0] res[2];
  logic [4:0] frz[2];
  logic [7:0] ofs[2];
  int mismatches = 0, cmp_count = 0, seed = 32'h32d4, cyc = 0, nstart = 0, t0, t1;
  // back-to-back spacing is one pass: two channels with a one-cycle converter take six cycles
  localparam int PER[4] = '{6, 200, 400, 800};

  tsv_regs #(.NCH(2), .INT_SHORT_CYC(32'd200), .INT_MID_CYC(32'd400),
    .INT_LONG_CYC(32'd800)) u_dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .chan_enable(chan_enable), .filter_on(filter_on), .conv_start(conv_start),
    .conv_chan(conv_chan), .conv_done(conv_done), .conv_raw(conv_raw), .busy(busy));
  tsv_conv_model u_conv (.mclk(mclk), .conv_start(conv_start), .conv_chan(conv_chan),
    .raws(raws), .delay(delay), .conv_done(conv_done), .conv_raw(conv_raw));

  // clock, cycle stamp and start counter
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (conv_start === 1'b1)
      nstart <= nstart + 1;
  end

  task automatic close_out;
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask : chk8

  // span between pass starts must equal the selected interval to the cycle
  task automatic chk_span(input string nm, input int exp, input int got);
    cmp_count++;
    if (got != exp)
    begin
      mismatches++;
      $display("ERROR %s exp %0d got %0d", nm, exp, got);
    end
  endtask : chk_span

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    rd_val = reg_rdata;
  endtask : rd

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk8(nm, exp, rd_val);
  endtask : rd_chk

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 2000)
    begin
      @(negedge mclk);
      n++;
    end
    chk8("busy", {7'h0, lvl}, {7'h0, busy});
  endtask : wait_busy

  task automatic wait_start(output int t);
    int n;
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (!(conv_start === 1'b1 && conv_chan === 2'd0) && n < 3000);
    t = cyc;
  endtask : wait_start

  // reference sum: offset lsb is half a degree, i.e. 16 result lsbs, then clamp
  function automatic logic [12:0] sum(input logic [12:0] raw, input logic [7:0] o);
    int s;
    s = int'(raw) + 16 * int'($signed(o));
    return (s < 0) ? 13'h0 : (s > 8191) ? 13'h1fff : 13'(s);
  endfunction : sum

  function automatic logic [7:0] lowb(input logic [4:0] f, input logic on);
    return {f[4:2], on ? f[1:0] : 2'b00, 3'b000};
  endfunction : lowb

  task automatic run_pass;
    wr(tsv_pkg::CMD_ONE_SHOT, 8'($random(seed)));
    wait_busy(1'b1);
    wait_busy(1'b0);
    for (int c = 0; c < 2; c++)
      if (chan_enable[c])
        res[c] = sum(raws[13*c +: 13], ofs[c]);
  endtask : run_pass

  // hang guard
  initial
  begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    close_out();
  end

  // main sequence
  initial
  begin
    reset = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata, filter_on, raws} = '0;
    chan_enable = 2'b11;
    delay = 5'd3;
    res = '{13'h0, 13'h0};
    ofs = '{8'h0, 8'h0};
    repeat (3) @(negedge mclk);
    reset = 1'b0;
    rd_chk("cfg", tsv_pkg::CMD_MAIN_CFG, 8'h00);
    rd_chk("interval", tsv_pkg::CMD_INTERVAL, 8'h02);
    rd_chk("ofs1", tsv_pkg::CMD_R1_OFFSET, 8'h00);
    rd_chk("ofs2", tsv_pkg::CMD_R2_OFFSET, 8'h00);
    rd_chk("wo read", tsv_pkg::CMD_ONE_SHOT, 8'h00);
    wr(tsv_pkg::CMD_MAIN_CFG, 8'hff);
    rd_chk("cfg", tsv_pkg::CMD_MAIN_CFG, 8'h40);
    wr(tsv_pkg::CMD_INTERVAL, 8'hfd);
    rd_chk("interval", tsv_pkg::CMD_INTERVAL, 8'h01);
    wait_busy(1'b0);
    repeat (250) @(negedge mclk);
    t0 = nstart;
    repeat (900) @(negedge mclk);
    chk8("hold starts", 8'h00, 8'(nstart - t0));
    for (int i = 0; i < 20; i++)
    begin
      chan_enable = 2'($random(seed));
      if (chan_enable == 2'b00)
        chan_enable = 2'b11;
      filter_on = 2'($random(seed));
      raws = 26'($random(seed));
      delay = 5'(1 + $unsigned($random(seed)) % 16);
      for (int c = 0; c < 2; c++)
      begin
        ofs[c] = 8'($random(seed));
        wr(8'(tsv_pkg::CMD_R1_OFFSET + c), ofs[c]);
        rd_chk("ofs", 8'(tsv_pkg::CMD_R1_OFFSET + c), ofs[c]);
      end
      wr(tsv_pkg::CMD_R1_HIGH, 8'h5a);
      run_pass();
      for (int c = 0; c < 2; c++)
      begin
        rd_chk("high", 8'(tsv_pkg::CMD_R1_HIGH + c), res[c][12:5]);
        frz[c] = res[c][4:0];
      end
      // fresh data lands between high and low reads on odd passes
      if (i % 2 == 1)
      begin
        raws = 26'($random(seed));
        run_pass();
      end
      for (int c = 0; c < 2; c++)
      begin
        rd_chk("low", 8'(tsv_pkg::CMD_R1_LOW + c),
          lowb(frz[c], filter_on[c]));
      end
    end
    delay = 5'd1;
    chan_enable = 2'b11;
    wr(tsv_pkg::CMD_MAIN_CFG, 8'h00);
    for (int s = 0; s < 4; s++)
    begin
      wr(tsv_pkg::CMD_INTERVAL, 8'(s));
      repeat (2) wait_start(t0);
      wait_start(t1);
      chk_span("period", PER[s], t1 - t0);
    end
    close_out();
  end
endmodule : temp_sensor_value_config_regs_tb
`default_nettype wire

// ==== tb/tsv_conv_model.sv ====
`default_nettype none
// converter stand-in: answers each start after a set delay
module tsv_conv_model (
  input wire logic mclk,
  input wire logic conv_start,
  input wire logic [1:0] conv_chan,
  input wire logic [25:0] raws,
  input wire logic [4:0] delay,
  output logic conv_done,
  output logic [12:0] conv_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] val;
  // data is inverted outside done so a late sample never looks valid; a start is
  // looked for on the very edge on which done drops, as the next channel follows at once
  initial
  begin
    val = 13'h0;
    conv_done = 1'b0;
    conv_raw = 13'h0;
    forever
    begin
      @(negedge mclk);
      conv_done = 1'b0;
      conv_raw = ~val;
      if (conv_start === 1'b1)
      begin
        val = conv_chan[0] ? raws[25:13] : raws[12:0];
        repeat (delay) @(negedge mclk);
        conv_done = 1'b1;
        conv_raw = val;
      end
    end
  end
endmodule : tsv_conv_model
`default_nettype wire

// ==== verilog/tsv_pkg.sv ====
`default_nettype none
package tsv_pkg;
  // command bytes
  localparam logic [7:0] CMD_MAIN_CFG = 8'h03;
  localparam logic [7:0] CMD_INTERVAL = 8'h04;
  localparam logic [7:0] CMD_ONE_SHOT = 8'h0f;
  localparam logic [7:0] CMD_R1_HIGH = 8'h19;
  localparam logic [7:0] CMD_R2_HIGH = 8'h1a;
  localparam logic [7:0] CMD_R1_LOW = 8'h29;
  localparam logic [7:0] CMD_R2_LOW = 8'h2a;
  localparam logic [7:0] CMD_R1_OFFSET = 8'h31;
  localparam logic [7:0] CMD_R2_OFFSET = 8'h32;
  // field positions and reset values
  localparam int HOLD_BIT = 6;
  localparam logic [7:0] MAIN_CFG_RST = 8'h00;
  localparam logic [1:0] INTERVAL_RST = 2'h2;
  localparam logic [7:0] OFFSET_RST = 8'h00;
  // result: 8 integer bits then 5 fraction bits, lsb 1/32 degree
  localparam int RES_W = 13;
  localparam int FRAC_W = 5;
  localparam logic [RES_W-1:0] RES_RST = 13'h0000;
  localparam logic [RES_W-1:0] RES_MAX = 13'h1fff;
  // interval timing
  localparam longint CLK_KHZ = 125000;
  localparam longint INT_SHORT_MS = 364;
  localparam longint INT_MID_MS = 1000;
  localparam longint INT_LONG_MS = 2500;
  localparam logic [31:0] INT_SHORT_CYC = 32'(INT_SHORT_MS * CLK_KHZ);
  localparam logic [31:0] INT_MID_CYC = 32'(INT_MID_MS * CLK_KHZ);
  localparam logic [31:0] INT_LONG_CYC = 32'(INT_LONG_MS * CLK_KHZ);
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT, ST_GAP} tsv_state_e;
endpackage : tsv_pkg
`default_nettype wire

// ==== verilog/tsv_regs.sv ====
// What this block does
// - the unsigned low byte holds 1/2, 1/4, 1/8 degree in bits 7..5 and bits 2..0 read zero.
// - low byte bit 4 reads zero with the filter off and the 1/16 degree bit with it on.
// - low byte bit 3 reads zero with the filter off and the 1/32 degree bit with it on.
// - each remote has a writable two's complement offset byte, lsb half a degree, reset 0.
// - the offset is added to the raw result and the corrected sum is what is reported.
// - with the hold bit set the block idles and converts only on a single-shot trigger.
// - the interval field picks back-to-back, 0.364 s, 1 s or 2.5 s, and resets to 1 s.
// - each interval converts the channels in turn and then idles for the rest of it.
// - unused bits of the config and interval registers ignore writes and read zero.
// - a write to the single-shot register in hold with the block idle runs one pass; the data is dropped.
// - reading a high byte freezes its low byte until that low byte is read.
`default_nettype none
module tsv_regs #(
  parameter int NCH = 2,
  parameter logic [31:0] INT_SHORT_CYC = tsv_pkg::INT_SHORT_CYC,
  parameter logic [31:0] INT_MID_CYC = tsv_pkg::INT_MID_CYC,
  parameter logic [31:0] INT_LONG_CYC = tsv_pkg::INT_LONG_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [NCH-1:0] chan_enable,
  input wire logic [NCH-1:0] filter_on,
  output logic conv_start,
  output logic [$clog2(NCH+1)-1:0] conv_chan,
  input wire logic conv_done,
  input wire logic [tsv_pkg::RES_W-1:0] conv_raw,
  output logic busy
);
  localparam int CW = $clog2(NCH + 1);

  logic low_power_hold_q;
  logic [1:0] sample_interval_sel_q;
  logic [7:0] offset_q [NCH];
  logic [tsv_pkg::RES_W-1:0] res_q [NCH];
  logic [7:0] low_lock_q [NCH];
  logic locked_q [NCH];
  tsv_pkg::tsv_state_e state_q;
  logic [CW-1:0] chan_q;
  logic [31:0] cnt_q;
  logic [31:0] period_q;
  logic single_pass_q;
  logic [7:0] rdata_q;

  // decode of the command port
  wire wr_cfg = reg_wr && (reg_addr == tsv_pkg::CMD_MAIN_CFG);
  wire wr_int = reg_wr && (reg_addr == tsv_pkg::CMD_INTERVAL);
  wire one_shot_go = reg_wr && (reg_addr == tsv_pkg::CMD_ONE_SHOT) && low_power_hold_q;
  wire chan_live = (chan_q < CW'(NCH)) && chan_enable[chan_q[$clog2(NCH)-1:0]];
  wire last_chan = (chan_q >= CW'(NCH));
  wire [31:0] period_sel = (sample_interval_sel_q == 2'h0) ? 32'h0000_0000 :
                           (sample_interval_sel_q == 2'h1) ? INT_SHORT_CYC :
                           (sample_interval_sel_q == 2'h2) ? INT_MID_CYC : INT_LONG_CYC;
  // the count is zero on the pass start edge, so one is added to make the
  // start-to-start spacing exactly the selected number of cycles
  wire gap_over = (cnt_q + 32'h0000_0001 >= period_q);

  // offset correction of the incoming raw value; clamps to the unsigned range
  wire [$clog2(NCH)-1:0] cidx = chan_q[$clog2(NCH)-1:0];
  wire [7:0] cur_off = offset_q[cidx];
  wire signed [14:0] off_ext = {{3{cur_off[7]}}, cur_off, 4'h0};
  wire signed [14:0] sum = $signed({2'b00, conv_raw}) + off_ext;
  wire [tsv_pkg::RES_W-1:0] corrected = sum[14] ? tsv_pkg::RES_RST :
                                        sum[13] ? tsv_pkg::RES_MAX : sum[12:0];

  // byte views of each result
  // the filter gate sits after the lock, so a frozen byte still obeys the filter setting
  logic [7:0] hi_byte [NCH];
  logic [7:0] lo_byte [NCH];
  logic [7:0] lo_src [NCH];
  logic [7:0] lo_view [NCH];
  for (genvar g = 0; g < NCH; g++)
  begin : g_view
    assign hi_byte[g] = res_q[g][12:5];
    assign lo_byte[g] = {res_q[g][4:0], 3'h0};
    assign lo_src[g] = locked_q[g] ? low_lock_q[g] : lo_byte[g];
    assign lo_view[g] = {lo_src[g][7:5],
                         filter_on[g] & lo_src[g][4],
                         filter_on[g] & lo_src[g][3],
                         3'h0};
  end

  // read mux; reserved bits and unmapped commands read zero
  wire [7:0] rd_mux =
    (reg_addr == tsv_pkg::CMD_MAIN_CFG) ? {1'b0, low_power_hold_q, 6'h00} :
    (reg_addr == tsv_pkg::CMD_INTERVAL) ? {6'h00, sample_interval_sel_q} :
    (reg_addr == tsv_pkg::CMD_R1_HIGH) ? hi_byte[0] :
    (reg_addr == tsv_pkg::CMD_R2_HIGH) ? hi_byte[1] :
    (reg_addr == tsv_pkg::CMD_R1_LOW) ? lo_view[0] :
    (reg_addr == tsv_pkg::CMD_R2_LOW) ? lo_view[1] :
    (reg_addr == tsv_pkg::CMD_R1_OFFSET) ? offset_q[0] :
    (reg_addr == tsv_pkg::CMD_R2_OFFSET) ? offset_q[1] : 8'h00;

  assign reg_rdata = rdata_q;
  assign busy = (state_q == tsv_pkg::ST_START) || (state_q == tsv_pkg::ST_WAIT);
  assign conv_start = (state_q == tsv_pkg::ST_START) && chan_live;
  assign conv_chan = chan_q;

  // control registers; only the documented bits are stored
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      low_power_hold_q <= tsv_pkg::MAIN_CFG_RST[tsv_pkg::HOLD_BIT];
      sample_interval_sel_q <= tsv_pkg::INTERVAL_RST;
      rdata_q <= 8'h00;
    end
    else
    begin
      if (wr_cfg)
        low_power_hold_q <= reg_wdata[tsv_pkg::HOLD_BIT];
      if (wr_int)
        sample_interval_sel_q <= reg_wdata[1:0];
      if (reg_rd)
        rdata_q <= rd_mux;
    end
  end

  // per-channel offset, result and low-byte lock
  for (genvar g = 0; g < NCH; g++)
  begin : g_chan
    wire wr_off = reg_wr && (reg_addr == tsv_pkg::CMD_R1_OFFSET + 8'(g));
    wire rd_hi = reg_rd && (reg_addr == tsv_pkg::CMD_R1_HIGH + 8'(g));
    wire rd_lo = reg_rd && (reg_addr == tsv_pkg::CMD_R1_LOW + 8'(g));
    wire store = (state_q == tsv_pkg::ST_WAIT) && conv_done && (int'(cidx) == g);
    always_ff @(posedge mclk or posedge reset)
    begin
      if (reset)
      begin
        offset_q[g] <= tsv_pkg::OFFSET_RST;
        res_q[g] <= tsv_pkg::RES_RST;
        low_lock_q[g] <= 8'h00;
        locked_q[g] <= 1'b0;
      end
      else
      begin
        if (wr_off)
          offset_q[g] <= reg_wdata;
        if (store)
          res_q[g] <= corrected;
        // a repeated high read re-latches; the high read wins over a same-cycle low read
        if (rd_hi)
        begin
          low_lock_q[g] <= lo_byte[g];
          locked_q[g] <= 1'b1;
        end
        else if (rd_lo)
          locked_q[g] <= 1'b0;
      end
    end
  end

  // sequencer: converts enabled channels in turn, then idles out the interval
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= tsv_pkg::ST_IDLE;
      chan_q <= '0;
      cnt_q <= 32'h0000_0000;
      period_q <= 32'h0000_0000;
      single_pass_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 32'h0000_0001;
      case (state_q)
        tsv_pkg::ST_IDLE:
        begin
          if (!low_power_hold_q || one_shot_go)
          begin
            state_q <= tsv_pkg::ST_START;
            chan_q <= '0;
            cnt_q <= 32'h0000_0000;
            period_q <= period_sel;
            single_pass_q <= low_power_hold_q;
          end
        end
        tsv_pkg::ST_START:
        begin
          if (last_chan)
            state_q <= single_pass_q ? tsv_pkg::ST_IDLE : tsv_pkg::ST_GAP;
          else if (chan_live)
            state_q <= tsv_pkg::ST_WAIT;
          else
            chan_q <= chan_q + CW'(1); // disabled channels are skipped
        end
        tsv_pkg::ST_WAIT:
        begin
          if (conv_done)
          begin
            state_q <= tsv_pkg::ST_START;
            chan_q <= chan_q + CW'(1);
          end
        end
        tsv_pkg::ST_GAP:
        begin
          // hold set during the gap ends autonomous running at once
          if (low_power_hold_q)
            state_q <= tsv_pkg::ST_IDLE;
          else if (gap_over)
          begin
            state_q <= tsv_pkg::ST_START;
            chan_q <= '0;
            cnt_q <= 32'h0000_0000;
            period_q <= period_sel;
          end
        end
        default:
          state_q <= tsv_pkg::ST_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_cfg_reserved;
    reg_rd && reg_addr == tsv_pkg::CMD_MAIN_CFG
      |=> reg_rdata[7] == 1'b0 && reg_rdata[5:0] == 6'h00;
  endproperty
  a_cfg_reserved: assert property (p_cfg_reserved)
    else $error("config reserved bits not zero");

  property p_int_reserved;
    reg_rd && reg_addr == tsv_pkg::CMD_INTERVAL |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_int_reserved: assert property (p_int_reserved)
    else $error("interval reserved bits not zero");

  property p_low_reserved;
    reg_rd && (reg_addr == tsv_pkg::CMD_R1_LOW || reg_addr == tsv_pkg::CMD_R2_LOW)
      |=> reg_rdata[2:0] == 3'h0;
  endproperty
  a_low_reserved: assert property (p_low_reserved)
    else $error("low byte bits 2..0 set");

  // holds for a frozen byte as well, since the gate follows the lock
  property p_filter_off;
    reg_rd && reg_addr == tsv_pkg::CMD_R1_LOW && !filter_on[0]
      |=> reg_rdata[4:3] == 2'h0;
  endproperty
  a_filter_off: assert property (p_filter_off)
    else $error("fine bits shown with filter off");

  property p_hold_idle;
    state_q == tsv_pkg::ST_IDLE && low_power_hold_q && !one_shot_go
      |=> state_q == tsv_pkg::ST_IDLE;
  endproperty
  a_hold_idle: assert property (p_hold_idle)
    else $error("converted while held");

  property p_one_shot;
    state_q == tsv_pkg::ST_IDLE && one_shot_go
      |=> state_q == tsv_pkg::ST_START ##0 single_pass_q;
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("single shot did not start a pass");

  property p_store_sum;
    state_q == tsv_pkg::ST_WAIT && conv_done && cidx == 0 && !sum[14] && !sum[13]
      |=> res_q[0] == $past(sum[12:0]);
  endproperty
  a_store_sum: assert property (p_store_sum)
    else $error("stored value is not raw plus offset");

  property p_lock_hold;
    reg_rd && reg_addr == tsv_pkg::CMD_R1_HIGH
      |=> locked_q[0] && low_lock_q[0] == $past(lo_byte[0]);
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("high read did not freeze low byte");

  property p_gap_len;
    state_q == tsv_pkg::ST_GAP && !low_power_hold_q && cnt_q + 32'h0000_0001 < period_q
      |=> state_q != tsv_pkg::ST_START;
  endproperty
  a_gap_len: assert property (p_gap_len)
    else $error("pass restarted before interval ended");

  property p_high_read;
    reg_rd && reg_addr == tsv_pkg::CMD_R1_HIGH |=> reg_rdata == $past(res_q[0][12:5]);
  endproperty
  a_high_read: assert property (p_high_read)
    else $error("high byte read is not the integer part");

  property p_offset_write;
    reg_wr && reg_addr == tsv_pkg::CMD_R2_OFFSET |=> offset_q[1] == $past(reg_wdata);
  endproperty
  a_offset_write: assert property (p_offset_write)
    else $error("offset write not kept");

  // a start held longer would launch the converter twice for one channel
  property p_start_pulse;
    conv_start |=> !conv_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("conversion start held beyond one cycle");

  property p_interval_latch;
    state_q == tsv_pkg::ST_GAP && !low_power_hold_q && gap_over
      |=> state_q == tsv_pkg::ST_START && period_q == $past(period_sel);
  endproperty
  a_interval_latch: assert property (p_interval_latch)
    else $error("new pass did not take the current interval");
endmodule : tsv_regs
`default_nettype wire
